// ==== include/sc_block_pkg.sv ====
// Behaviour
// RL1: Comparator bus enable clear keeps the block off the comparator bus, set drives its result.
// RL2: Offset nulling off keeps the shorting switch open and both input branches on the amp.
// RL3: Offset nulling on shorts in phase one, grounds branches in phase one, amp in phase two.
// RL4: The five-bit C capacitor size is an unsigned count of 0 to 31 unit capacitors.
// RL5: Integrator switch control clear holds the integrating capacitor switch open.
// RL6: Integrator switch control set with nulling off holds that switch closed.
// RL7: Integrator switch control set with nulling on closes that switch only in phase two.
// RL8: Output ground switch is open when its control is clear, closed only in phase one if set.
// RL9: Reference select 00 gives analog ground, 01 the high reference, 10 the low reference.
// RL10: Reference select 11 follows the comparator, high reference when high, low when low.
// RL11: The B input select picks one of four sources from a fixed table for each instance.
// RL12: Power code 00 is off and codes 01, 10, 11 give rising bias levels.
// RL13: The third control register clears to zero at reset and stays readable and writable.
// RL14: Each instance's second and third registers decode at fixed offsets in both banks.
// RL15: Analog column bus enable clear puts the block's analog bus output in high impedance.
// RL16: The comparator result is caught on phase one's rising edge and held through phase two.
`default_nettype none
package sc_block_pkg;
  localparam int NBLK = 4;
  localparam int IDX_W = 9;
  localparam logic [7:0] CTRL2_IDX [NBLK] = '{8'h82, 8'h8A, 8'h96, 8'h9E};
  localparam logic [7:0] CTRL3_IDX [NBLK] = '{8'h83, 8'h88, 8'h97, 8'h9F};
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam int ANA_OE_BIT = 7;
  localparam int CMP_OE_BIT = 6;
  localparam int NULL_BIT = 5;
  localparam int CSIZE_LSB = 0;
  localparam int CSIZE_W = 5;
  localparam int AREF_LSB = 6;
  localparam int INTSW_BIT = 5;
  localparam int GNDSW_BIT = 4;
  localparam int BSEL_LSB = 2;
  localparam int PWR_LSB = 0;
  localparam logic [1:0] AREF_GND = 2'h0;
  localparam logic [1:0] AREF_HIGH = 2'h1;
  localparam logic [1:0] AREF_LOW = 2'h2;
  localparam logic [1:0] AREF_CMP = 2'h3;
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam int SRC_W = 4;
  localparam logic [3:0] SRC_CT00 = 4'h0;
  localparam logic [3:0] SRC_CT02 = 4'h1;
  localparam logic [3:0] SRC_SB11 = 4'h2;
  localparam logic [3:0] SRC_SB13 = 4'h3;
  localparam logic [3:0] SRC_SB20 = 4'h4;
  localparam logic [3:0] SRC_SB22 = 4'h5;
  localparam logic [3:0] SRC_PIN23 = 4'h6;
  localparam logic [3:0] SRC_PIN20 = 4'h7;
  localparam logic [3:0] SRC_ABUS3 = 4'h8;
  localparam logic [3:0] SRC_AGND = 4'h9;
  localparam logic [3:0] BSRC_TABLE [NBLK][4] = '{
    '{SRC_CT00, SRC_SB11, SRC_PIN23, SRC_SB20},
    '{SRC_CT02, SRC_SB13, SRC_SB11, SRC_SB22},
    '{SRC_SB11, SRC_SB20, SRC_SB22, SRC_AGND},
    '{SRC_SB13, SRC_SB22, SRC_PIN20, SRC_ABUS3}};
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b10} bus_state_e;
endpackage
`default_nettype wire

// ==== hw/sc_block_switch_control.sv ====
`default_nettype none
module sc_block_switch_control
  import sc_block_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [10:0]                 adr_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  input  wire logic                        phase1,
  input  wire logic                        phase2,
  input  wire logic [sc_block_pkg::NBLK-1:0] compareIn,
  output logic      [sc_block_pkg::NBLK-1:0] compareBusOut,
  output logic      [sc_block_pkg::NBLK-1:0] compareBusOe,
  output logic      [sc_block_pkg::NBLK-1:0] analogBusOe,
  output logic      [sc_block_pkg::NBLK-1:0] shortSwitch,
  output logic      [sc_block_pkg::NBLK-1:0] branchToGround,
  output logic      [sc_block_pkg::NBLK-1:0] branchToAmp,
  output logic      [sc_block_pkg::NBLK-1:0] intCapSwitch,
  output logic      [sc_block_pkg::NBLK-1:0] outGndSwitch,
  output logic      [sc_block_pkg::NBLK-1:0] refGround,
  output logic      [sc_block_pkg::NBLK-1:0] refHigh,
  output logic      [sc_block_pkg::NBLK-1:0] refLow,
  output logic      [sc_block_pkg::NBLK-1:0] blockOn,
  output logic      [4*sc_block_pkg::NBLK-1:0] cBranchCap4,
  output logic      [5*sc_block_pkg::NBLK-1:0] cBranchCap,
  output logic      [4*sc_block_pkg::NBLK-1:0] bSource,
  output logic      [2*sc_block_pkg::NBLK-1:0] powerLevel
);
  import sc_block_pkg::*;

  bus_state_e        busState;
  logic [7:0]        ctrl2 [NBLK];
  logic [7:0]        ctrl3 [NBLK];
  logic              phase1Prev;
  logic [NBLK-1:0]   compareHeld;
  logic [IDX_W-1:0]  regIdx;
  logic [NBLK-1:0]   hit2;
  logic [NBLK-1:0]   hit3;
  logic [7:0]        next_readData;
  logic              writeNow;

  // Reference routing: {ground, high, low}
  function automatic logic [2:0] refRoute(input logic [1:0] code, input logic cmp);
    unique case (code)
      AREF_GND:  refRoute = 3'b100;
      AREF_HIGH: refRoute = 3'b010;
      AREF_LOW:  refRoute = 3'b001;
      AREF_CMP:  refRoute = cmp ? 3'b010 : 3'b001;
    endcase
  endfunction

  // Bank bit ignored so both banks alias
  assign regIdx = adr_i[10:2];

  always_comb
  begin
    hit2 = '0;
    hit3 = '0;
    next_readData = 8'h00;
    for (int b = 0; b < NBLK; b++)
    begin
      hit2[b] = (regIdx[7:0] == CTRL2_IDX[b]); // RL14
      hit3[b] = (regIdx[7:0] == CTRL3_IDX[b]); // RL14
      if (hit2[b])
        next_readData = ctrl2[b];
      if (hit3[b])
        next_readData = ctrl3[b];
    end
  end

  assign writeNow = ack_o && cyc_i && stb_i && we_i && sel_i[0];

  // Bus handshake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busState <= ST_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      unique case (busState)
        ST_IDLE:
          if (cyc_i && stb_i)
          begin
            busState <= ST_ACK;
            ack_o <= 1'b1;
            dat_o <= {24'h00_0000, next_readData};
          end
        ST_ACK:
        begin
          busState <= ST_IDLE;
          ack_o <= 1'b0;
        end
        default:
        begin
          busState <= ST_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

  // Register writes at the acknowledging edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        ctrl2[b] <= CTRL2_RESET;
        ctrl3[b] <= CTRL3_RESET; // RL13
      end
    end
    else if (writeNow)
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        if (hit2[b])
          ctrl2[b] <= dat_i[7:0];
        if (hit3[b])
          ctrl3[b] <= dat_i[7:0]; // RL13
      end
    end
  end

  // Comparator capture on phase one rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase1Prev <= 1'b0;
      compareHeld <= '0;
    end
    else
    begin
      phase1Prev <= phase1;
      if (phase1 && !phase1Prev)
        compareHeld <= compareIn; // RL16
    end
  end

  // Comparator and analog bus enables
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compareBusOut <= '0;
      compareBusOe <= '0;
      analogBusOe <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        compareBusOe[b] <= ctrl2[b][CMP_OE_BIT]; // RL1
        compareBusOut[b] <= ctrl2[b][CMP_OE_BIT] & compareHeld[b]; // RL1
        analogBusOe[b] <= ctrl2[b][ANA_OE_BIT]; // RL15
      end
    end
  end

  // Offset nulling switches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shortSwitch <= '0;
      branchToGround <= '0;
      branchToAmp <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        if (ctrl2[b][NULL_BIT])
        begin
          shortSwitch[b] <= phase1; // RL3
          branchToGround[b] <= phase1; // RL3
          branchToAmp[b] <= phase2; // RL3
        end
        else
        begin
          shortSwitch[b] <= 1'b0; // RL2
          branchToGround[b] <= 1'b0; // RL2
          branchToAmp[b] <= 1'b1; // RL2
        end
      end
    end
  end

  // Integrator and output ground switches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intCapSwitch <= '0;
      outGndSwitch <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        if (!ctrl3[b][INTSW_BIT])
          intCapSwitch[b] <= 1'b0; // RL5
        else if (!ctrl2[b][NULL_BIT])
          intCapSwitch[b] <= 1'b1; // RL6
        else
          intCapSwitch[b] <= phase2; // RL7
        outGndSwitch[b] <= ctrl3[b][GNDSW_BIT] & phase1; // RL8
      end
    end
  end

  // A branch reference routing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refGround <= '0;
      refHigh <= '0;
      refLow <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        {refGround[b], refHigh[b], refLow[b]} <=
          refRoute(ctrl3[b][AREF_LSB +: 2], compareHeld[b]); // RL9 RL10
      end
    end
  end

  // Capacitor size and B source
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cBranchCap <= '0;
      cBranchCap4 <= '0;
      bSource <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        cBranchCap[CSIZE_W*b +: CSIZE_W] <= ctrl2[b][CSIZE_LSB +: CSIZE_W]; // RL4
        cBranchCap4[4*b +: 4] <= BSRC_TABLE[b][ctrl3[b][BSEL_LSB +: 2]]; // RL11
        bSource[4*b +: 4] <= BSRC_TABLE[b][ctrl3[b][BSEL_LSB +: 2]]; // RL11
      end
    end
  end

  // Power level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      powerLevel <= '0;
      blockOn <= '0;
    end
    else
    begin
      for (int b = 0; b < NBLK; b++)
      begin
        powerLevel[2*b +: 2] <= ctrl3[b][PWR_LSB +: 2]; // RL12
        blockOn[b] <= (ctrl3[b][PWR_LSB +: 2] != PWR_OFF); // RL12
      end
    end
  end

  for (genvar g = 0; g < NBLK; g++)
  begin : gChk
    comp_bus_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
      !ctrl2[g][CMP_OE_BIT] |=> !compareBusOe[g] && !compareBusOut[g])
      else $error("comparator bus driven while disabled");
    null_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RL2
      !ctrl2[g][NULL_BIT] |=> !shortSwitch[g] && branchToAmp[g] && !branchToGround[g])
      else $error("switches wrong with nulling off");
    null_on_a: assert property (@(posedge clk) disable iff (!rst_n) // RL3
      ctrl2[g][NULL_BIT] |=> shortSwitch[g] == $past(phase1) && branchToAmp[g] == $past(phase2))
      else $error("switches wrong with nulling on");
    int_switch_a: assert property (@(posedge clk) disable iff (!rst_n) // RL7
      ctrl3[g][INTSW_BIT] && ctrl2[g][NULL_BIT] |=> intCapSwitch[g] == $past(phase2))
      else $error("integrator switch not gated by phase two");
    int_open_a: assert property (@(posedge clk) disable iff (!rst_n) // RL5
      !ctrl3[g][INTSW_BIT] |=> !intCapSwitch[g])
      else $error("integrator switch closed while disabled");
    gnd_switch_a: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      outGndSwitch[g] |-> $past(ctrl3[g][GNDSW_BIT]) && $past(phase1))
      else $error("ground switch closed outside phase one");
    ref_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
      ctrl3[g][AREF_LSB +: 2] == AREF_CMP |=> refHigh[g] == $past(compareHeld[g]) && refLow[g] != refHigh[g])
      else $error("reference not following comparator");
    cmp_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RL16
      !(phase1 && !phase1Prev) |=> $stable(compareHeld[g]))
      else $error("comparator latch changed outside phase one rise");
    power_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RL12
      ctrl3[g][PWR_LSB +: 2] == PWR_OFF |=> !blockOn[g])
      else $error("block on with power code off");

    power_on_a: assert property (@(posedge clk) disable iff (!rst_n) // RL12
      ctrl3[g][PWR_LSB +: 2] != PWR_OFF |=> blockOn[g])
      else $error("block off with power code on");

    power_level_a: assert property (@(posedge clk) disable iff (!rst_n) // RL12
      1'b1 |=> powerLevel[2*g +: 2] == $past(ctrl3[g][PWR_LSB +: 2]))
      else $error("power level does not follow its field");

    cap_size_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
      1'b1 |=> cBranchCap[CSIZE_W*g +: CSIZE_W] == $past(ctrl2[g][CSIZE_LSB +: CSIZE_W]))
      else $error("capacitor size does not follow its field");

    int_closed_a: assert property (@(posedge clk) disable iff (!rst_n) // RL6
      ctrl3[g][INTSW_BIT] && !ctrl2[g][NULL_BIT] |=> intCapSwitch[g])
      else $error("integrator switch open with nulling off");

    gnd_open_a: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      !ctrl3[g][GNDSW_BIT] |=> !outGndSwitch[g])
      else $error("ground switch closed while disabled");

    ref_ground_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
      ctrl3[g][AREF_LSB +: 2] == AREF_GND |=> refGround[g] && !refHigh[g] && !refLow[g])
      else $error("reference not analog ground");

    ref_high_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
      ctrl3[g][AREF_LSB +: 2] == AREF_HIGH |=> !refGround[g] && refHigh[g] && !refLow[g])
      else $error("reference not high input");

    ref_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
      ctrl3[g][AREF_LSB +: 2] == AREF_LOW |=> !refGround[g] && !refHigh[g] && refLow[g])
      else $error("reference not low input");

    b_source_a: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      1'b1 |=> bSource[4*g +: 4] == $past(BSRC_TABLE[g][ctrl3[g][BSEL_LSB +: 2]]))
      else $error("B source not from instance table");

    b_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      cBranchCap4[4*g +: 4] == bSource[4*g +: 4])
      else $error("B source copies differ");

    ana_bus_a: assert property (@(posedge clk) disable iff (!rst_n) // RL15
      1'b1 |=> analogBusOe[g] == $past(ctrl2[g][ANA_OE_BIT]))
      else $error("analog bus enable does not follow its bit");

    cmp_capture_a: assert property (@(posedge clk) disable iff (!rst_n) // RL16
      phase1 && !phase1Prev |=> compareHeld[g] == $past(compareIn[g]))
      else $error("comparator not caught on phase one rise");

    cmp_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
      ctrl2[g][CMP_OE_BIT] |=> compareBusOe[g] && compareBusOut[g] == $past(compareHeld[g]))
      else $error("comparator result not driven while enabled");

    reg_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RL13
      writeNow && hit3[g] |=> ctrl3[g] == $past(dat_i[7:0]))
      else $error("third control register write lost");
  end

  bus_ack_a: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  ack_answer_a: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");

  read_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

endmodule // sc_block_switch_control
`default_nettype wire

// ==== verif/tb_sc_block_switch_control.sv ====
`default_nettype none
module tb_sc_block_switch_control;
  import sc_block_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        p1 = 1'b0;
  logic        p2 = 1'b0;
  logic [10:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [3:0]  cmpIn = '0;
  logic [31:0] datI = '0;
  logic [31:0] datO;
  logic        ack;
  logic [3:0]  cbo, cbe, abe, sh, bg, ba, ic, og, rg, rh, rl, on;
  logic [15:0] cc4, bs;
  logic [19:0] cc;
  logic [7:0]  pl, rd;
  int          n_fail = 0;
  int          total_checks = 0;

  always #4 clk = ~clk;

  sc_block_switch_control DUT (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .phase1(p1), .phase2(p2), .compareIn(cmpIn), .compareBusOut(cbo),
    .compareBusOe(cbe), .analogBusOe(abe), .shortSwitch(sh), .branchToGround(bg),
    .branchToAmp(ba), .intCapSwitch(ic), .outGndSwitch(og), .refGround(rg),
    .refHigh(rh), .refLow(rl), .blockOn(on), .cBranchCap4(cc4), .cBranchCap(cc),
    .bSource(bs), .powerLevel(pl));

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic w, s, bk, input logic [7:0] ix, wd);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= {3'h0, s};
    adr <= {bk, ix, 2'h0};
    datI <= {24'h0, wd};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED %0t bus timeout", $time);
      finish_test();
    end
    rd = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, v);
    bus(1'b1, 1'b1, 1'b0, ix, v);
  endtask

  task automatic rc(input logic [7:0] ix, e);
    bus(1'b0, 1'b1, 1'b0, ix, 8'h00);
    chk(rd, e);
  endtask

  task automatic ph(input logic a, b);
    @(posedge clk);
    p1 <= a;
    p2 <= b;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    for (int b = 0; b < 4; b++)
    begin
      rc(CTRL2_IDX[b], 8'h00);
      rc(CTRL3_IDX[b], 8'h00);
    end
    chk(on, 4'h0);
    chk(ba, 4'hF);
  endtask

  task automatic t_bus;
    bus(1'b1, 1'b1, 1'b1, CTRL3_IDX[0], 8'h5A);
    rc(CTRL3_IDX[0], 8'h5A);
    bus(1'b0, 1'b1, 1'b1, CTRL3_IDX[0], 8'h00);
    chk(rd, 8'h5A);
    wr(8'h84, 8'hFF);
    rc(8'h84, 8'h00);
    bus(1'b1, 1'b0, 1'b0, CTRL3_IDX[0], 8'h11);
    rc(CTRL3_IDX[0], 8'h5A);
    wr(CTRL3_IDX[0], 8'h00);
  endtask

  task automatic t_ctrl2;
    logic [4:0] cp [4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
    logic [7:0] v;
    @(posedge clk);
    cmpIn <= 4'hF;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b1);
    for (int b = 0; b < 4; b++)
      wr(CTRL2_IDX[b], {2'(b), 1'b0, cp[b]});
    settle();
    for (int b = 0; b < 4; b++)
    begin
      v = {2'(b), 1'b0, cp[b]};
      chk(cbe[b], v[6]);
      chk(cbo[b], v[6]);
      chk(abe[b], v[7]);
      chk(cc[5*b+:5], cp[b]);
      rc(CTRL2_IDX[b], v);
      wr(CTRL2_IDX[b], 8'h00);
    end
  endtask

  task automatic t_sw;
    for (int nz = 0; nz < 2; nz++)
      for (int fs = 0; fs < 4; fs++)
        for (int p = 0; p < 2; p++)
        begin
          wr(CTRL2_IDX[2], nz ? 8'h20 : 8'h00);
          wr(CTRL3_IDX[2], 8'(fs << 4));
          ph(p[0], !p[0]);
          settle();
          chk(sh[2], nz && p);
          chk(bg[2], nz && p);
          chk(ba[2], !nz || !p);
          chk(ic[2], fs[1] && (!nz || !p));
          chk(og[2], fs[0] && p);
        end
    wr(CTRL2_IDX[2], 8'h00);
  endtask

  task automatic t_ref;
    for (int c = 0; c < 4; c++)
      for (int cv = 0; cv < 2; cv++)
      begin
        wr(CTRL3_IDX[3], 8'(c << 6));
        @(posedge clk);
        cmpIn[3] <= cv[0];
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b0);
        @(posedge clk);
        cmpIn[3] <= !cv[0];
        ph(1'b0, 1'b1);
        settle();
        chk(rg[3], c == 0);
        chk(rh[3], c == 1 || (c == 3 && cv));
        chk(rl[3], c == 2 || (c == 3 && !cv));
      end
  endtask

  task automatic t_bp;
    for (int b = 0; b < 4; b++)
      for (int c = 0; c < 4; c++)
      begin
        wr(CTRL3_IDX[b], 8'((c << 2) | c));
        settle();
        chk(bs[4*b+:4], BSRC_TABLE[b][c]);
        chk(cc4[4*b+:4], BSRC_TABLE[b][c]);
        chk(pl[2*b+:2], c);
        chk(on[b], c != 0);
        rc(CTRL3_IDX[b], 8'((c << 2) | c));
      end
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    t_reset();
    t_bus();
    t_ctrl2();
    t_sw();
    t_ref();
    t_bp();
    finish_test();
  end
endmodule // tb_sc_block_switch_control
`default_nettype wire
